// file: scm_map.vh
// constants for the miscellaneous system-control block
// assumes inclusion by bare name; definitions only
`ifndef SCM_MAP_VH
`define SCM_MAP_VH
`define SCM_BANKS 8
`define SCM_BANK_W 3
`define SCM_NMI_W 4
`define SCM_NMI_PIN 0
`define SCM_NMI_PWR 1
`define SCM_NMI_SUP 2
`define SCM_NMI_CLK 3
`define SCM_NMI_RST 4'h0
`define SCM_PER_W 16
`define SCM_PER_DMA 15
`define SCM_PER_WDOG 14
`define SCM_PER_CONV 13
`define SCM_PER_SER_HI 12
`define SCM_PER_SER_LO 5
`define SCM_PER_WIDE 4
`define SCM_PER_NAR_HI 3
`define SCM_PER_NAR_LO 0
`define SCM_PER_RST 16'h0000
`define SCM_PWR_RST 8'hff
`define SCM_RET_RST 8'h01
`define SCM_RET_PIN 8'h01
`define SCM_RETAIN_RST 8'h00
`define SCM_FLAG_RST 1'b0
`define SCM_SRC_RST 1'b0
`define SCM_GLITCH_RST 1'b1
`define SCM_RTYPE_FULL 1'b1
`define SCM_RTYPE_SOFT 1'b0
`define SCM_RTYPE_RST 1'b1
`define SCM_SIZE_W 32
`define SCM_SRAM_BYTES 32'h00010000
`define SCM_FLASH_BYTES 32'h00040000
`endif

// file: scm_ctrl.v
// miscellaneous system control: nmi gating, memory bank power and
// retention, reset-pin glitch enable, halt-follow, watchdog reset type.
// assumes fault inputs arrive from other clock domains; commands are
// same-domain one-cycle strobes from the cpu's register logic.
`timescale 1ns/1ns
`default_nettype none
`include "scm_map.vh"

// What this block does
// - disabling a bank tier also powers down every higher bank
// - enabling a bank tier also powers every lower bank
// - lowest bank always powered, never disabled by writes
// - after reset, retention of all banks but the lowest is off
// - lowest bank retention always active
// - in deep sleep only banks with retention set are retained
// - retention bits set independently in any combination
// - enabled nmi source fault raises the nmi flag
// - disabled nmi source fault never sets the nmi flag
// - four nmi source enables, any combination per write
// - reset pin glitch suppression enable, switchable
// - after reset all peripherals keep running at cpu halt
// - per-peripheral halt-follow control, stops selected ones at halt
// - software selects reset type on watchdog violation
// - separate full or soft type for timeout and password violation
// - read-only sram and flash sizes
module scm_ctrl (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire i_bank_en_wr,
    input wire i_bank_dis_wr,
    input wire [`SCM_BANK_W-1:0] i_bank_tier,
    input wire i_ret_en_wr,
    input wire i_ret_dis_wr,
    input wire [`SCM_BANKS-1:0] i_ret_mask,
    input wire i_deep_sleep_mode,
    input wire i_nmi_en_wr,
    input wire i_nmi_dis_wr,
    input wire [`SCM_NMI_W-1:0] i_nmi_mask,
    input wire i_nmi_external_pin_source,
    input wire i_nmi_power_controller_source,
    input wire i_nmi_supply_supervisor_source,
    input wire i_nmi_clock_system_source,
    input wire i_nmi_flag_clr,
    input wire i_glitch_en_wr,
    input wire i_glitch_dis_wr,
    input wire i_halt_en_wr,
    input wire i_halt_dis_wr,
    input wire [`SCM_PER_W-1:0] i_halt_mask,
    input wire i_cpu_halted,
    input wire i_wdog_timeout_type_wr,
    input wire i_wdog_passwd_type_wr,
    input wire i_reset_type,
    output reg [`SCM_BANKS-1:0] o_bank_power,
    output reg [`SCM_BANKS-1:0] o_bank_retain,
    output reg [`SCM_BANKS-1:0] o_ret_status,
    output reg [`SCM_NMI_W-1:0] o_nmi_status,
    output reg o_nmi_flag,
    output reg o_glitch_filter_en,
    output reg [`SCM_PER_W-1:0] o_halt_follow,
    output reg [`SCM_PER_W-1:0] o_periph_stop,
    output reg o_wdog_timeout_full_reset_type,
    output reg o_wdog_passwd_full_reset_type,
    output reg [`SCM_SIZE_W-1:0] o_sram_size,
    output reg [`SCM_SIZE_W-1:0] o_flash_size
);

wire [`SCM_NMI_W-1:0] src_sync;
reg [`SCM_BANKS-1:0] pwr_d;
wire [`SCM_BANKS-1:0] ret_d;
wire [`SCM_NMI_W-1:0] nmi_en_d;
wire [`SCM_PER_W-1:0] halt_d;
reg nmi_flag_d;
wire [`SCM_BANKS-1:0] tier_up;
wire [`SCM_BANKS-1:0] tier_low;
wire [`SCM_BANKS-1:0] ret_state;
wire nmi_hit;
genvar g;

// thermometer masks for the addressed tier
generate
    for (g = 0; g < `SCM_BANKS; g = g + 1) begin : g_tier
        assign tier_up[g] = (g >= i_bank_tier);
        assign tier_low[g] = (g <= i_bank_tier);
    end
endgenerate

// each fault line crosses from its own domain through two stages;
// a fault reaches the flag logic one clock after it is sampled, sources hold levels
scm_sync2 #(
    .RST_VAL(`SCM_SRC_RST)
) u_sync_pin (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async(i_nmi_external_pin_source),
    .o_sync(src_sync[`SCM_NMI_PIN])
);

scm_sync2 #(
    .RST_VAL(`SCM_SRC_RST)
) u_sync_pwr (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async(i_nmi_power_controller_source),
    .o_sync(src_sync[`SCM_NMI_PWR])
);

scm_sync2 #(
    .RST_VAL(`SCM_SRC_RST)
) u_sync_sup (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async(i_nmi_supply_supervisor_source),
    .o_sync(src_sync[`SCM_NMI_SUP])
);

scm_sync2 #(
    .RST_VAL(`SCM_SRC_RST)
) u_sync_clk (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async(i_nmi_clock_system_source),
    .o_sync(src_sync[`SCM_NMI_CLK])
);

always @* begin
    pwr_d = o_bank_power;
    if (i_bank_en_wr)
        pwr_d = o_bank_power | tier_low;
    if (i_bank_dis_wr)
        pwr_d = pwr_d & ~tier_up;
    pwr_d[0] = 1'b1;
end

scm_setclr #(
    .W(`SCM_BANKS),
    .PIN(`SCM_RET_PIN)
) u_ret_next (
    .i_set(i_ret_en_wr),
    .i_clr(i_ret_dis_wr),
    .i_mask(i_ret_mask),
    .i_cur(o_ret_status),
    .o_next(ret_d)
);

// retain only selected banks in deep sleep
assign ret_state = i_deep_sleep_mode ? ret_d : `SCM_RETAIN_RST;

scm_setclr #(
    .W(`SCM_NMI_W)
) u_nmi_next (
    .i_set(i_nmi_en_wr),
    .i_clr(i_nmi_dis_wr),
    .i_mask(i_nmi_mask),
    .i_cur(o_nmi_status),
    .o_next(nmi_en_d)
);

assign nmi_hit = |(src_sync & o_nmi_status);

always @* begin
    // set wins over a same-cycle clear
    nmi_flag_d = nmi_hit | (o_nmi_flag & ~i_nmi_flag_clr);
end

scm_setclr #(
    .W(`SCM_PER_W)
) u_halt_next (
    .i_set(i_halt_en_wr),
    .i_clr(i_halt_dis_wr),
    .i_mask(i_halt_mask),
    .i_cur(o_halt_follow),
    .o_next(halt_d)
);

// memory bank power and retention state
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        o_bank_power <= `SCM_PWR_RST;
        o_ret_status <= `SCM_RET_RST;
        o_bank_retain <= `SCM_RETAIN_RST;
    end else if (i_ce) begin
        o_bank_power <= pwr_d;
        o_ret_status <= ret_d;
        // power and retention stay orthogonal; a retained bank that
        // is powered down simply holds nothing worth keeping
        o_bank_retain <= ret_state;
    end
end

// nmi enables and the sticky flag
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        o_nmi_status <= `SCM_NMI_RST;
        o_nmi_flag <= `SCM_FLAG_RST;
    end else if (i_ce) begin
        o_nmi_status <= nmi_en_d;
        o_nmi_flag <= nmi_flag_d;
    end
end

always @(posedge i_clk) begin
    if (i_sys_rst) begin
        o_glitch_filter_en <= `SCM_GLITCH_RST;
    end else if (i_ce) begin
        if (i_glitch_en_wr)
            o_glitch_filter_en <= 1'b1;
        else if (i_glitch_dis_wr)
            o_glitch_filter_en <= 1'b0;
    end
end

// halt-follow selection and the stop requests it drives
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        o_halt_follow <= `SCM_PER_RST;
        o_periph_stop <= `SCM_PER_RST;
    end else if (i_ce) begin
        o_halt_follow <= halt_d;
        // stop selected peripherals while halted
        // next selection used so a write during halt acts at once
        o_periph_stop <= i_cpu_halted ? halt_d : `SCM_PER_RST;
    end
end

always @(posedge i_clk) begin
    if (i_sys_rst) begin
        o_wdog_timeout_full_reset_type <= `SCM_RTYPE_RST;
        o_wdog_passwd_full_reset_type <= `SCM_RTYPE_RST;
    end else if (i_ce) begin
        if (i_wdog_timeout_type_wr)
            o_wdog_timeout_full_reset_type <= i_reset_type;
        if (i_wdog_passwd_type_wr)
            o_wdog_passwd_full_reset_type <= i_reset_type;
    end
end

// fixed size readback, registered so the outputs stay flops
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        o_sram_size <= `SCM_SRAM_BYTES;
        o_flash_size <= `SCM_FLASH_BYTES;
    end else if (i_ce) begin
        o_sram_size <= `SCM_SRAM_BYTES;
        o_flash_size <= `SCM_FLASH_BYTES;
    end
end

endmodule

// two-stage synchroniser for one level from a foreign clock domain;
// only the second stage leaves, so a metastable first stage never
// reaches any logic
module scm_sync2 #(
    parameter [0:0] RST_VAL = 1'b0
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire i_async,
    output wire o_sync
);

reg meta_q;
reg sync_q;

always @(posedge i_clk) begin
    if (i_sys_rst) begin
        meta_q <= RST_VAL;
        sync_q <= RST_VAL;
    end else if (i_ce) begin
        meta_q <= i_async;
        sync_q <= meta_q;
    end
end

assign o_sync = sync_q;

endmodule

// next value of a word of set/clear control bits; set goes first so
// a clear in the same write wins, and bits in PIN are forced on
// because software must never be able to drop them
module scm_setclr #(
    parameter W = 8,
    parameter [W-1:0] PIN = {W{1'b0}}
) (
    input wire i_set,
    input wire i_clr,
    input wire [W-1:0] i_mask,
    input wire [W-1:0] i_cur,
    output reg [W-1:0] o_next
);

always @* begin
    o_next = i_cur;
    if (i_set)
        o_next = o_next | i_mask;
    if (i_clr)
        o_next = o_next & ~i_mask;
    o_next = o_next | PIN;
end

endmodule
`default_nettype wire

// file: scm_ctrl_props.sv
// assertions for the system-control block
// assumes attachment by bind to scm_ctrl, one clock domain
`timescale 1ns/1ns
`default_nettype none
module scm_ctrl_props (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_bank_en_wr,
    input wire logic i_bank_dis_wr,
    input wire logic [2:0] i_bank_tier,
    input wire logic i_deep_sleep_mode,
    input wire logic i_cpu_halted,
    input wire logic i_nmi_external_pin_source,
    input wire logic i_nmi_power_controller_source,
    input wire logic i_nmi_supply_supervisor_source,
    input wire logic i_nmi_clock_system_source,
    input wire logic [7:0] o_bank_power,
    input wire logic [7:0] o_bank_retain,
    input wire logic [7:0] o_ret_status,
    input wire logic [3:0] o_nmi_status,
    input wire logic o_nmi_flag,
    input wire logic [15:0] o_periph_stop
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    chk_bank0_power: assert property (o_bank_power[0])
        else $error("lowest bank unpowered");
    chk_power_contig: assert property
        (((o_bank_power + 8'h01) & o_bank_power) == 8'h00)
        else $error("power not contiguous");
    chk_dis_tier: assert property
        (i_ce && i_bank_dis_wr && i_bank_tier != 3'h0
        |=> !o_bank_power[$past(i_bank_tier)]) else $error("tier on");
    chk_en_tier: assert property
        (i_ce && i_bank_en_wr && !i_bank_dis_wr
        |=> o_bank_power[$past(i_bank_tier)]) else $error("tier off");
    chk_ret0_kept: assert property (o_ret_status[0])
        else $error("lowest retention off");
    chk_retain_sleep: assert property
        ($past(i_ce) && $past(i_deep_sleep_mode)
        |-> o_bank_retain == o_ret_status) else $error("retain set");
    chk_retain_awake: assert property
        ($past(i_ce) && !$past(i_deep_sleep_mode)
        |-> o_bank_retain == 8'h00) else $error("retain awake");
    chk_stop_running: assert property
        ($past(i_ce) && !$past(i_cpu_halted)
        |-> o_periph_stop == 16'h0000) else $error("stop unhalted");
    chk_nmi_gated: assert property
        ($rose(o_nmi_flag) && $past(i_ce) && $past(i_ce, 2)
        && $past(i_ce, 3)
        |-> ($past({i_nmi_clock_system_source,
        i_nmi_supply_supervisor_source, i_nmi_power_controller_source,
        i_nmi_external_pin_source}, 3) & $past(o_nmi_status)) != 4'h0)
        else $error("nmi gated");
    cover property (i_bank_dis_wr && i_bank_tier != 3'h0);
    cover property ($rose(o_nmi_flag));
    cover property (o_bank_retain != 8'h00);
endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the system-control block
// assumes scm_ctrl and scm_map.vh are compiled with it
`timescale 1ns/1ns
`default_nettype none
`include "scm_map.vh"
module tb_top;
    logic i_clk = 0, i_sys_rst = 1, i_ce = 1, i_deep_sleep_mode = 0;
    logic i_cpu_halted = 0, i_reset_type = 0;
    logic [3:0] src = 0, i_nmi_mask = 0;
    logic [2:0] i_bank_tier = 0;
    logic [7:0] i_ret_mask = 0;
    logic [15:0] i_halt_mask = 0;
    logic [12:0] st = 0;
    int bad_count = 0, num_checks = 0;
    wire i_bank_en_wr = st[0], i_bank_dis_wr = st[1], i_ret_en_wr = st[2],
        i_ret_dis_wr = st[3], i_nmi_en_wr = st[4], i_nmi_dis_wr = st[5],
        i_glitch_en_wr = st[6], i_glitch_dis_wr = st[7],
        i_halt_en_wr = st[8], i_halt_dis_wr = st[9], i_nmi_flag_clr = st[12],
        i_wdog_timeout_type_wr = st[10], i_wdog_passwd_type_wr = st[11],
        i_nmi_external_pin_source = src[0],
        i_nmi_power_controller_source = src[1],
        i_nmi_supply_supervisor_source = src[2],
        i_nmi_clock_system_source = src[3];
    wire [7:0] o_bank_power, o_bank_retain, o_ret_status;
    wire [3:0] o_nmi_status;
    wire o_nmi_flag, o_glitch_filter_en;
    wire o_wdog_timeout_full_reset_type, o_wdog_passwd_full_reset_type;
    wire [15:0] o_halt_follow, o_periph_stop;
    wire [31:0] o_sram_size, o_flash_size;
    scm_ctrl DUT (.*);
    always #5 i_clk = ~i_clk;
    task chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h, expected %h", $time, g, e);
        end
    endtask
    // strobe held one full cycle, launched off the sampling edge
    task pulse(input int b);
        st[b] = 1'b1;
        @(negedge i_clk);
        st[b] = 1'b0;
    endtask
    task banks;
        i_bank_tier = 3'h5;
        pulse(1);
        chk(o_bank_power, 32'h1f);
        i_bank_tier = 3'h0;
        pulse(1);
        chk(o_bank_power, 32'h01);
        i_bank_tier = 3'h3;
        pulse(0);
        chk(o_bank_power, 32'h0f);
    endtask
    task freeze;
        i_ce = 1'b0;
        i_bank_tier = 3'h7;
        pulse(0);
        chk(o_bank_power, 32'h0f);
        i_ce = 1'b1;
    endtask
    task rerun;
        i_ret_mask = 8'h80;
        pulse(2);
        chk(o_ret_status, 32'h81);
        i_sys_rst = 1'b1;
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk(o_ret_status, 32'h01);
        chk(o_halt_follow, 32'h0);
        chk(o_periph_stop, 32'h0);
        chk(o_nmi_status, 32'h0);
        chk(o_wdog_passwd_full_reset_type, 32'h1);
        @(negedge i_clk);
        chk(o_periph_stop, 32'h0);
    endtask
    task retention;
        chk(o_ret_status, 32'h01);
        i_ret_mask = 8'ha4;
        pulse(2);
        chk(o_ret_status, 32'ha5);
        i_deep_sleep_mode = 1'b1;
        @(negedge i_clk);
        chk(o_bank_retain, 32'ha5);
        i_ret_mask = 8'hff;
        pulse(3);
        chk(o_bank_retain, 32'h01);
        i_deep_sleep_mode = 1'b0;
        @(negedge i_clk);
        chk(o_bank_retain, 32'h00);
    endtask
    task nmi;
        i_nmi_mask = 4'h5;
        pulse(4);
        chk(o_nmi_status, 32'h5);
        src = 4'h8;
        repeat (6) @(negedge i_clk);
        chk(o_nmi_flag, 32'h0);
        src = 4'h1;
        repeat (4) @(negedge i_clk);
        chk(o_nmi_flag, 32'h1);
        // let the synchroniser drain, else set beats clear
        src = 4'h0;
        repeat (3) @(negedge i_clk);
        pulse(12);
        chk(o_nmi_flag, 32'h0);
        i_nmi_mask = 4'ha;
        pulse(4);
        chk(o_nmi_status, 32'hf);
        i_nmi_mask = 4'hf;
        pulse(5);
        chk(o_nmi_status, 32'h0);
    endtask
    task misc;
        chk(o_sram_size, `SCM_SRAM_BYTES);
        chk(o_flash_size, `SCM_FLASH_BYTES);
        chk(o_halt_follow, 32'h0);
        i_halt_mask = 16'h8001;
        pulse(8);
        i_cpu_halted = 1'b1;
        @(negedge i_clk);
        chk(o_periph_stop, 32'h8001);
        i_halt_mask = 16'h8000;
        pulse(9);
        chk(o_halt_follow, 32'h0001);
        chk(o_periph_stop, 32'h0001);
        pulse(10);
        chk(o_wdog_timeout_full_reset_type, 32'h0);
        chk(o_wdog_passwd_full_reset_type, 32'h1);
        i_reset_type = 1'b1;
        pulse(10);
        chk(o_wdog_timeout_full_reset_type, 32'h1);
        i_reset_type = 1'b0;
        pulse(11);
        chk(o_wdog_passwd_full_reset_type, 32'h0);
        chk(o_wdog_timeout_full_reset_type, 32'h1);
        pulse(7);
        chk(o_glitch_filter_en, 32'h0);
        pulse(6);
        chk(o_glitch_filter_en, 32'h1);
    endtask
    task finish_test;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge i_clk);
        i_sys_rst = 1'b0;
        banks;
        freeze;
        retention;
        nmi;
        misc;
        rerun;
        finish_test;
    end
    initial begin
        #5000;
        bad_count++;
        finish_test;
    end
endmodule
bind scm_ctrl scm_ctrl_props u_props (.*);
`default_nettype wire
